/* File: inc/alert_route_pkg.sv */
/*
 * Constants for the first alert pin routing block: register offset,
 * field positions of the routing mask, reset value and pulse timing.
 * Assumes a 100 MHz block clock.
 */
package alert_route_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam logic [ADDR_W-1:0] ALERT_PIN1_ROUTE_MASK_ADDR = 8'h27;
    localparam logic [DATA_W-1:0] ROUTE_MASK_RESET = 24'h000000;
    // Bit 0 is unimplemented and reads zero
    localparam logic [DATA_W-1:0] ROUTE_MASK_WRITABLE = 24'hfffffe;

    // ------------------------------------------------------------
    // Field positions (channel 1 at the top bit of each group)
    // ------------------------------------------------------------
    localparam int CHAN_N = 4;
    localparam int OVERCURRENT_LSB = 20;
    localparam int UNDERCURRENT_LSB = 16;
    localparam int OVERVOLTAGE_LSB = 12;
    localparam int UNDERVOLTAGE_LSB = 8;
    localparam int OVERPOWER_LSB = 4;
    localparam int ACCUMULATOR_FULL_BIT = 3;
    localparam int SAMPLE_TALLY_FULL_BIT = 2;
    localparam int CONV_DONE_PULSE_BIT = 1;
    localparam int UNUSED_BIT = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int CONV_PULSE_TIME_NS = 5000;
    localparam int CONV_PULSE_CYCLES = (CONV_PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int PULSE_CNT_W = 16;

endpackage

/* File: src/alert_pin1_routing_mask.sv */
/*
 * Routing mask for the first shared alert / low-rate pin.
 * Holds the 24-bit routing register, combines tripped conditions with
 * their enables, adds the conversion-complete pulse and drives the
 * open-drain pin when its function is set to alert.
 * Assumes tripped conditions, conversion strobe and pin function select
 * come synchronous from the comparators and configuration logic.
 */
`timescale 1ns/1ps
module alert_pin1_routing_mask
    import alert_route_pkg::*;
#(
    parameter int PULSE_CYCLES = alert_route_pkg::CONV_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [alert_route_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [alert_route_pkg::DATA_W-1:0] reg_wdata,
    output logic [alert_route_pkg::DATA_W-1:0] reg_rdata,
    // Tripped conditions, same layout as the routing mask
    input wire logic [alert_route_pkg::DATA_W-1:0] alert_tripped,
    input wire logic conv_done,
    // Pin function select: high means alert
    input wire logic pin_func_alert,
    // Shared pin, open drain, active low
    input wire logic shared_alert_pin_one_in,
    output logic shared_alert_pin_one_out,
    output logic shared_alert_pin_one_oe_n,
    // Low-rate sampling request to the conversion sequencer
    output logic slow_request,
    // Internal view of the pin drive: alert level gated by the alert pin function
    output logic alert_active
);

    import alert_route_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Routing register
    // ------------------------------------------------------------
    logic [DATA_W-1:0] route_mask_q;
    logic [DATA_W-1:0] route_mask_d;
    logic addr_hit;
    logic mask_wr;

    assign addr_hit = (reg_addr == ALERT_PIN1_ROUTE_MASK_ADDR);
    assign mask_wr = reg_wr && addr_hit;
    // Unimplemented bit never stored
    assign route_mask_d = mask_wr ? (reg_wdata & ROUTE_MASK_WRITABLE) : route_mask_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            route_mask_q <= ROUTE_MASK_RESET;
        end else begin
            route_mask_q <= route_mask_d;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // Unmapped addresses read zero
    assign rdata_d = !reg_rd ? rdata_q :
                     addr_hit ? (route_mask_q & ROUTE_MASK_WRITABLE) : '0;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Field views of the mask
    // ------------------------------------------------------------
    logic [CHAN_N-1:0] oc_route;
    logic [CHAN_N-1:0] uc_route;
    logic [CHAN_N-1:0] ov_route;
    logic [CHAN_N-1:0] uv_route;
    logic [CHAN_N-1:0] op_route;
    logic accumulator_full_route;
    logic sample_tally_full_route;
    logic conversion_done_pulse_enable;

    assign oc_route = route_mask_q[OVERCURRENT_LSB +: CHAN_N];
    assign uc_route = route_mask_q[UNDERCURRENT_LSB +: CHAN_N];
    assign ov_route = route_mask_q[OVERVOLTAGE_LSB +: CHAN_N];
    assign uv_route = route_mask_q[UNDERVOLTAGE_LSB +: CHAN_N];
    assign op_route = route_mask_q[OVERPOWER_LSB +: CHAN_N];
    assign accumulator_full_route = route_mask_q[ACCUMULATOR_FULL_BIT];
    assign sample_tally_full_route = route_mask_q[SAMPLE_TALLY_FULL_BIT];
    assign conversion_done_pulse_enable = route_mask_q[CONV_DONE_PULSE_BIT];

    // ------------------------------------------------------------
    // Field views of the tripped conditions
    // ------------------------------------------------------------
    logic [CHAN_N-1:0] oc_trip;
    logic [CHAN_N-1:0] uc_trip;
    logic [CHAN_N-1:0] ov_trip;
    logic [CHAN_N-1:0] uv_trip;
    logic [CHAN_N-1:0] op_trip;
    logic acc_full_trip;
    logic tally_full_trip;

    assign oc_trip = alert_tripped[OVERCURRENT_LSB +: CHAN_N];
    assign uc_trip = alert_tripped[UNDERCURRENT_LSB +: CHAN_N];
    assign ov_trip = alert_tripped[OVERVOLTAGE_LSB +: CHAN_N];
    assign uv_trip = alert_tripped[UNDERVOLTAGE_LSB +: CHAN_N];
    assign op_trip = alert_tripped[OVERPOWER_LSB +: CHAN_N];
    assign acc_full_trip = alert_tripped[ACCUMULATOR_FULL_BIT];
    assign tally_full_trip = alert_tripped[SAMPLE_TALLY_FULL_BIT];

    // ------------------------------------------------------------
    // Routed condition combine
    // ------------------------------------------------------------
    logic current_hit;
    logic voltage_hit;
    logic power_hit;
    logic accum_hit;
    logic routed_any;

    assign current_hit = |(oc_trip & oc_route) | |(uc_trip & uc_route);
    assign voltage_hit = |(ov_trip & ov_route) | |(uv_trip & uv_route);
    assign power_hit = |(op_trip & op_route);
    assign accum_hit = (acc_full_trip & accumulator_full_route)
                     | (tally_full_trip & sample_tally_full_route);
    // Level, not latched: the status side keeps the condition sticky
    assign routed_any = current_hit | voltage_hit | power_hit | accum_hit;

    // ------------------------------------------------------------
    // Conversion-complete pulse
    // ------------------------------------------------------------
    logic conv_pulse_start;
    logic conv_pulse_busy;

    // Enable sampled at the conversion end; clearing it later does not cut the pulse
    assign conv_pulse_start = conv_done && conversion_done_pulse_enable;

    conv_pulse_timer #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .CNT_W(PULSE_CNT_W)
    ) u_conv_pulse (
        .clk(clk),
        .rst_n(rst_n_q),
        .start(conv_pulse_start),
        .busy(conv_pulse_busy)
    );

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic alert_level;
    logic drive_low;
    logic pin_oe_n_d;
    logic pin_oe_n_q;
    logic alert_active_q;

    assign alert_level = routed_any | conv_pulse_busy;
    // Pin left alone in low-rate mode
    assign drive_low = pin_func_alert && alert_level;
    // Enable kept in its own flop so the pin sees no gate after it
    assign pin_oe_n_d = !drive_low;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_oe_n_q <= 1'b1;
            alert_active_q <= 1'b0;
        end else begin
            pin_oe_n_q <= pin_oe_n_d;
            alert_active_q <= drive_low;
        end
    end

    // ------------------------------------------------------------
    // Output data is a constant low flop; only the enable moves
    // ------------------------------------------------------------
    logic pin_data_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_data_q <= 1'b0;
        end else begin
            pin_data_q <= 1'b0;
        end
    end

    assign shared_alert_pin_one_out = pin_data_q;
    assign shared_alert_pin_one_oe_n = pin_oe_n_q;
    assign alert_active = alert_active_q;

    // ------------------------------------------------------------
    // Low-rate sampling control
    // ------------------------------------------------------------
    logic slow_d;
    logic slow_q;

    // Pin input ignored entirely in alert mode so own drive cannot echo back
    assign slow_d = !pin_func_alert && shared_alert_pin_one_in;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            slow_q <= 1'b0;
        end else begin
            slow_q <= slow_d;
        end
    end

    assign slow_request = slow_q;

endmodule // alert_pin1_routing_mask

/* File: src/conv_pulse_timer.sv */
/*
 * Fixed-length pulse timer: a start strobe raises the output for
 * PULSE_CYCLES clocks. A fresh start restarts the count.
 * Assumes a synchronous, already released active-low reset.
 */
`timescale 1ns/1ps
module conv_pulse_timer #(
    parameter int PULSE_CYCLES = 500,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    output logic busy
);

    logic [CNT_W-1:0] remain_q;
    logic [CNT_W-1:0] remain_d;
    logic busy_q;
    logic busy_d;

    localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    assign remain_d = start ? LOAD_VAL :
                      (busy_q && remain_q != '0) ? remain_q - ONE : remain_q;
    assign busy_d = start ? 1'b1 : (busy_q && remain_q != '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain_q <= '0;
            busy_q <= 1'b0;
        end else begin
            remain_q <= remain_d;
            busy_q <= busy_d;
        end
    end

    assign busy = busy_q;

endmodule // conv_pulse_timer

/* File: tb/alert_host_model.sv */
/* Host side of the shared alert pin: pull-up, open-drain resolution
   and a host sink used as the low-rate control level.
   Assumes the device enable is active low. */
`timescale 1ns/1ps
module alert_host_model (
    // Device side
    input wire logic pin_out,
    input wire logic pin_oe_n,
    // Host side
    input wire logic host_pull_low,
    output logic pin_level
);
    // Pull-up holds the line high unless a party sinks it
    assign pin_level = !((!pin_oe_n && !pin_out) || host_pull_low);
endmodule // alert_host_model

/* File: tb/alert_route_checker.sv */
/* Port assertions for the first alert pin routing block.
   Assumes binding into alert_pin1_routing_mask, 5-cycle pulse. */
`timescale 1ns/1ps
module alert_route_checker
    import alert_route_pkg::*;
(
    // Watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire logic [alert_route_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [alert_route_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [alert_route_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [alert_route_pkg::DATA_W-1:0] alert_tripped,
    input wire logic conv_done,
    input wire logic pin_func_alert,
    input wire logic shared_alert_pin_one_in,
    input wire logic shared_alert_pin_one_oe_n,
    input wire logic slow_request,
    input wire logic alert_active
);
    // Shadow mask; delayed enable covers the two-flop reset release
    logic [DATA_W-1:0] mask_q;
    logic [2:0] up_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_q <= '0;
            up_q <= '0;
        end else begin
            up_q <= {up_q[1:0], 1'b1};
            if (reg_wr && reg_addr == ALERT_PIN1_ROUTE_MASK_ADDR)
                mask_q <= reg_wdata & ROUTE_MASK_WRITABLE;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!up_q[2]);
    sequence conv_start;
        conv_done && mask_q[CONV_DONE_PULSE_BIT] && pin_func_alert;
    endsequence
    route_on_a: assert property (pin_func_alert && |(alert_tripped & mask_q & 24'hfffffc)
        |=> !shared_alert_pin_one_oe_n) else $error("routed alert not driven");
    func_off_a: assert property (!pin_func_alert |=> shared_alert_pin_one_oe_n)
        else $error("pin driven outside alert mode");
    active_mirror_a: assert property (alert_active == !shared_alert_pin_one_oe_n)
        else $error("alert level and pin differ");
    slow_block_a: assert property (pin_func_alert |=> !slow_request)
        else $error("low-rate request in alert mode");
    slow_pass_a: assert property (!pin_func_alert
        |=> slow_request == $past(shared_alert_pin_one_in)) else $error("low-rate not passed");
    bit0_zero_a: assert property (reg_rd |=> !reg_rdata[UNUSED_BIT])
        else $error("unused bit read as one");
    read_back_a: assert property (reg_rd && reg_addr == ALERT_PIN1_ROUTE_MASK_ADDR
        |=> reg_rdata == $past(mask_q)) else $error("mask readback wrong");
    // Five matches the pulse length the bench sets
    conv_pulse_a: assert property (conv_start |-> ##2 (!shared_alert_pin_one_oe_n)[*5])
        else $error("conversion pulse too short");
endmodule // alert_route_checker

bind alert_pin1_routing_mask alert_route_checker i_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alert_tripped(alert_tripped),
    .conv_done(conv_done), .pin_func_alert(pin_func_alert),
    .shared_alert_pin_one_in(shared_alert_pin_one_in),
    .shared_alert_pin_one_oe_n(shared_alert_pin_one_oe_n),
    .slow_request(slow_request), .alert_active(alert_active));

/* File: tb/tb_top.sv */
/* Self-checking bench for the first alert pin routing block.
   Assumes a 100 MHz clock and a 5-cycle pulse in simulation. */
`timescale 1ns/1ps
module tb_top;
    import alert_route_pkg::*;
    logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, conv_done = 0;
    logic pin_func_alert = 1, host_pull_low = 0, pin_level, pin_out, pin_oe_n;
    logic slow_request, alert_active;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 24'h0, reg_rdata, alert_tripped = 24'h0;
    int err_total = 0, checks = 0, lows;
    // Short pulse keeps the run brief; the checker counts the same length
    localparam int SIM_PULSE = 5;
    always #5 clk = !clk;
    alert_pin1_routing_mask #(.PULSE_CYCLES(SIM_PULSE)) i_dut (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alert_tripped(alert_tripped),
        .conv_done(conv_done), .pin_func_alert(pin_func_alert),
        .shared_alert_pin_one_in(pin_level), .shared_alert_pin_one_out(pin_out),
        .shared_alert_pin_one_oe_n(pin_oe_n), .slow_request(slow_request),
        .alert_active(alert_active));
    alert_host_model i_host (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .host_pull_low(host_pull_low), .pin_level(pin_level));
    // ----------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------
    task chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task rd(input logic [ADDR_W-1:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
        rd(8'h27);
        chk("mask reset", reg_rdata, 24'h000000);
        wr(8'h27, 24'hffffff);
        wr(8'h28, 24'h000000);
        rd(8'h27);
        chk("mask all", reg_rdata, 24'hfffffe);
        rd(8'h28);
        chk("unmapped", reg_rdata, 24'h000000);
        // Each bit 2 to 23 routed alone: the other conditions leave the pin high, its own pulls it low
        for (int b = 2; b < 24; b++) begin
            wr(8'h27, 24'h1 << b);
            alert_tripped = ~(24'h1 << b);
            @(negedge clk);
            chk("unrouted", pin_level, 24'h1);
            alert_tripped = 24'h1 << b;
            @(negedge clk);
            chk("routed", pin_level, 24'h0);
            chk("alert active", alert_active, 24'h1);
            chk("pin data", pin_out, 24'h0);
            alert_tripped = 24'h0;
        end
        wr(8'h27, 24'hfffffe);
        alert_tripped = 24'hfffffc;
        pin_func_alert = 0;
        @(negedge clk);
        chk("pin off", pin_level, 24'h1);
        chk("slow high", slow_request, 24'h1);
        host_pull_low = 1;
        @(negedge clk);
        chk("slow low", slow_request, 24'h0);
        host_pull_low = 0;
        alert_tripped = 24'h0;
        pin_func_alert = 1;
        @(negedge clk);
        chk("slow blocked", slow_request, 24'h0);
        for (int m = 0; m < 2; m++) begin
            wr(8'h27, m ? 24'h000002 : 24'h000000);
            conv_done = 1;
            @(negedge clk);
            conv_done = 0;
            lows = 0;
            repeat (10) begin
                @(negedge clk);
                if (pin_level === 1'b0) lows++;
            end
            chk("pulse cycles", DATA_W'(lows), m ? DATA_W'(SIM_PULSE) : 24'h0);
        end
        // Mid-run reset drops every routing bit
        wr(8'h27, 24'hfffffe);
        alert_tripped = 24'hfffffc;
        @(negedge clk);
        chk("pre reset", pin_level, 24'h0);
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
        chk("reset pin", pin_level, 24'h1);
        chk("reset active", alert_active, 24'h0);
        rd(8'h27);
        chk("reset mask", reg_rdata, 24'h000000);
        alert_tripped = 24'h0;
        end_of_test;
    end
    // Tests need about 150 cycles; this limit is far beyond
    initial begin
        #20000;
        err_total++;
        end_of_test;
    end
endmodule // tb_top
